// ### rtl/dhs_chan.sv
// Purpose: One automatic-direction channel, card open-drain to line pair
// Assumes: All pin levels synchronous to clk
// Notes: Minus line is never pulled; the bias network lifts it

module dhs_chan
	import dhs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic connect,
	input wire logic card_i,
	input wire logic plus_i,
	input wire logic minus_i,
	output logic line_level,
	output logic card_oe,
	output logic plus_oe
);

	dhs_dir_e dir_ff;
	dhs_dir_e nxt_dir;

	// Only the difference counts, common mode is ignored
	assign line_level = plus_i & ~minus_i;

	// ----------------------------------------------------------------
	// Direction: whoever pulls low first owns the channel until release
	// ----------------------------------------------------------------
	always_comb begin
		nxt_dir = dir_ff;
		unique case (dir_ff)
		DIR_IDLE: begin
			if (!card_i) begin
				nxt_dir = DIR_TO_LINE;
			end else if (!line_level) begin
				nxt_dir = DIR_TO_CARD;
			end
		end
		DIR_TO_LINE: begin
			if (card_i) begin
				nxt_dir = DIR_IDLE;
			end
		end
		DIR_TO_CARD: begin
			if (line_level) begin
				nxt_dir = DIR_IDLE;
			end
		end
		endcase
		if (!connect) begin
			nxt_dir = DIR_IDLE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_ff <= DIR_IDLE;
		end else begin
			dir_ff <= nxt_dir;
		end
	end

	// Enables come straight from one-hot state flops
	assign card_oe = dir_ff[2];
	assign plus_oe = dir_ff[1];

	property p_one_dir;
		@(posedge clk) disable iff (!arst_n)
		!(card_oe && plus_oe);
	endproperty
	a_one_dir: assert property (p_one_dir)
		else $error("channel drives both sides");

	property p_isolated;
		@(posedge clk) disable iff (!arst_n)
		!connect |=> !card_oe && !plus_oe;
	endproperty
	a_isolated: assert property (p_isolated)
		else $error("channel drives while disconnected");

	property p_rx_diff;
		@(posedge clk) disable iff (!arst_n)
		(dir_ff == DIR_IDLE && connect && card_i && plus_i == minus_i)
			|=> card_oe;
	endproperty
	a_rx_diff: assert property (p_rx_diff)
		else $error("equal pair levels not taken as low");

endmodule

// ### rtl/dhs_connect.sv
// Purpose: Hot-swap sequencing and connection of three bridged channels
// Assumes: Supply and termination comparators deliver synchronous levels
// Notes: APB slave answers with zero wait states
//
// Design decisions made here: the register addresses and the APB slave port.

module dhs_connect
	import dhs_pkg::*;
#(
	parameter int unsigned POR_CYC = POR_CYC_DEF,
	parameter int unsigned TERM_CYC = TERM_CYC_DEF,
	parameter int unsigned IDLE_CYC = IDLE_CYC_DEF
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic supply_ok,
	input wire logic enable_level,
	input wire logic enable_driven,
	input wire logic clock_term_ok,
	input wire logic data_term_ok,
	input wire logic card_clock_i,
	output logic card_clock_o,
	output logic card_clock_oe,
	input wire logic card_data_i,
	output logic card_data_o,
	output logic card_data_oe,
	input wire logic card_irq_i,
	output logic card_irq_o,
	output logic card_irq_oe,
	input wire logic line_clock_plus_i,
	output logic line_clock_plus_o,
	output logic line_clock_plus_oe,
	input wire logic line_clock_minus_i,
	output logic line_clock_minus_o,
	output logic line_clock_minus_oe,
	input wire logic line_data_plus_i,
	output logic line_data_plus_o,
	output logic line_data_plus_oe,
	input wire logic line_data_minus_i,
	output logic line_data_minus_o,
	output logic line_data_minus_oe,
	input wire logic line_irq_plus_i,
	output logic line_irq_plus_o,
	output logic line_irq_plus_oe,
	input wire logic line_irq_minus_i,
	output logic line_irq_minus_o,
	output logic line_irq_minus_oe,
	output logic plugin_detect_n_o,
	output logic plugin_detect_n_oe,
	output logic ready_n_o,
	output logic ready_n_oe,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
	localparam logic [CNT_W-1:0] TERM_LAST = CNT_W'(TERM_CYC - 1);
	localparam logic [IDLE_W-1:0] IDLE_RST = IDLE_W'(IDLE_CYC);

	dhs_state_e state_ff;
	dhs_state_e nxt_state;
	logic [CNT_W-1:0] por_cnt_ff;
	logic [CNT_W-1:0] nxt_por_cnt;
	logic [CNT_W-1:0] term_cnt_ff;
	logic [CNT_W-1:0] nxt_term_cnt;
	logic [IDLE_W-1:0] idle_cnt_ff;
	logic [IDLE_W-1:0] nxt_idle_cnt;
	logic data_lvl_ff;
	logic ctrl_en_ff;
	logic [IDLE_W-1:0] idle_time_ff;
	logic [31:0] prdata_ff;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_idle = paddr == REG_IDLE;
	wire hit_status = paddr == REG_STATUS;
	wire hit_any = hit_ctrl | hit_idle | hit_status;
	wire setup_rd = psel & ~penable & ~pwrite;
	wire wr_en = psel & penable & pwrite;
	wire wr_ctrl = wr_en & hit_ctrl;
	wire wr_idle = wr_en & hit_idle;
	// Status is read-only, a write there is refused as well
	wire bad_access = ~hit_any | (pwrite & hit_status);
	wire reseq = wr_ctrl & pwdata[CTRL_RESEQ_BIT];

	// ----------------------------------------------------------------
	// Sequencing conditions
	// ----------------------------------------------------------------
	// Pad pull-up: nobody driving the pin reads as high
	wire pin_en = ~enable_driven | enable_level;
	wire en_eff = pin_en & ctrl_en_ff;
	wire term_valid = clock_term_ok & data_term_ok;
	wire conn = state_ff == ST_CONNECTED;
	wire plugged = (state_ff == ST_ARMED) | conn;
	wire clk_lvl;
	wire data_lvl;
	wire por_done = por_cnt_ff == POR_LAST;
	wire term_done = term_cnt_ff == TERM_LAST;
	// Stop: data rises while clock stays high
	wire stop_det = clk_lvl & data_lvl & ~data_lvl_ff;
	wire card_idle = card_clock_i & card_data_i;
	wire lines_high = line_clock_plus_i & line_data_plus_i;
	// Zero in the idle register acts as one cycle
	wire idle_done = lines_high & (idle_cnt_ff >= idle_time_ff)
		& (idle_cnt_ff != '0);
	wire join_ok = (stop_det & card_idle) | idle_done;

	// ----------------------------------------------------------------
	// Hot-swap state machine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
		ST_POWERUP: begin
			if (por_done) begin
				nxt_state = ST_TERM_CHECK;
			end
		end
		ST_TERM_CHECK: begin
			if (term_valid) begin
				nxt_state = ST_TERM_WAIT;
			end
		end
		ST_TERM_WAIT: begin
			// Termination must hold through the whole wait
			if (!term_valid) begin
				nxt_state = ST_TERM_CHECK;
			end else if (term_done) begin
				nxt_state = ST_ARMED;
			end
		end
		ST_ARMED: begin
			if (!term_valid) begin
				nxt_state = ST_POWERUP;
			end else if (en_eff && join_ok) begin
				nxt_state = ST_CONNECTED;
			end
		end
		ST_CONNECTED: begin
			if (!term_valid) begin
				nxt_state = ST_POWERUP;
			end else if (!en_eff) begin
				nxt_state = ST_ARMED;
			end
		end
		endcase
		// Power loss or software request restarts from the beginning
		if (!supply_ok || reseq) begin
			nxt_state = ST_POWERUP;
		end
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	always_comb begin
		nxt_por_cnt = '0;
		if (state_ff == ST_POWERUP && supply_ok && !por_done) begin
			nxt_por_cnt = por_cnt_ff + CNT_W'(1);
		end
	end

	always_comb begin
		nxt_term_cnt = '0;
		if (state_ff == ST_TERM_WAIT && term_valid && !term_done) begin
			nxt_term_cnt = term_cnt_ff + CNT_W'(1);
		end
	end

	// Saturates so a long idle bus stays qualified
	always_comb begin
		nxt_idle_cnt = '0;
		if (lines_high) begin
			nxt_idle_cnt = idle_cnt_ff;
			if (idle_cnt_ff != '1) begin
				nxt_idle_cnt = idle_cnt_ff + IDLE_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_POWERUP;
			por_cnt_ff <= '0;
			term_cnt_ff <= '0;
			idle_cnt_ff <= '0;
			data_lvl_ff <= 1'h1;
		end else begin
			state_ff <= nxt_state;
			por_cnt_ff <= nxt_por_cnt;
			term_cnt_ff <= nxt_term_cnt;
			idle_cnt_ff <= nxt_idle_cnt;
			data_lvl_ff <= data_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	dhs_chan u_clock (
		.clk(clk),
		.arst_n(arst_n),
		.connect(conn),
		.card_i(card_clock_i),
		.plus_i(line_clock_plus_i),
		.minus_i(line_clock_minus_i),
		.line_level(clk_lvl),
		.card_oe(card_clock_oe),
		.plus_oe(line_clock_plus_oe)
	);

	dhs_chan u_data (
		.clk(clk),
		.arst_n(arst_n),
		.connect(conn),
		.card_i(card_data_i),
		.plus_i(line_data_plus_i),
		.minus_i(line_data_minus_i),
		.line_level(data_lvl),
		.card_oe(card_data_oe),
		.plus_oe(line_data_plus_oe)
	);

	// Same channel again; an unused one sees its card pin tied low
	dhs_chan u_irq (
		.clk(clk),
		.arst_n(arst_n),
		.connect(conn),
		.card_i(card_irq_i),
		.plus_i(line_irq_plus_i),
		.minus_i(line_irq_minus_i),
		.line_level(),
		.card_oe(card_irq_oe),
		.plus_oe(line_irq_plus_oe)
	);

	// ----------------------------------------------------------------
	// Pins: open-drain, only ever pull low
	// ----------------------------------------------------------------
	assign card_clock_o = PIN_LOW;
	assign card_data_o = PIN_LOW;
	assign card_irq_o = PIN_LOW;
	assign line_clock_plus_o = PIN_LOW;
	assign line_data_plus_o = PIN_LOW;
	assign line_irq_plus_o = PIN_LOW;
	// Released minus keeps plus at or below it while plus is pulled
	assign line_clock_minus_o = PIN_LOW;
	assign line_clock_minus_oe = PIN_LOW;
	assign line_data_minus_o = PIN_LOW;
	assign line_data_minus_oe = PIN_LOW;
	assign line_irq_minus_o = PIN_LOW;
	assign line_irq_minus_oe = PIN_LOW;
	assign plugin_detect_n_o = PIN_LOW;
	assign plugin_detect_n_oe = plugged;
	assign ready_n_o = PIN_LOW;
	assign ready_n_oe = conn;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	wire [31:0] status_val = {22'h0, term_valid, supply_ok, en_eff,
		plugged, conn, state_ff};
	wire [31:0] rd_val = hit_ctrl ? {31'h0, ctrl_en_ff} :
		hit_idle ? {16'h0, idle_time_ff} :
		hit_status ? status_val : 32'h0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_en_ff <= CTRL_EN_RST;
			idle_time_ff <= IDLE_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_en_ff <= pwdata[CTRL_EN_BIT];
			end
			if (wr_idle) begin
				idle_time_ff <= pwdata[IDLE_W-1:0];
			end
		end
	end

	// Read data captured in setup so it stands through the access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= 32'h0;
		end else if (setup_rd) begin
			prdata_ff <= rd_val;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'h1;
	assign pslverr = psel & penable & bad_access;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_disabled;
		@(posedge clk) disable iff (!arst_n)
		!en_eff |=> !ready_n_oe ##1 !card_data_oe && !card_clock_oe
			&& !card_irq_oe;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("connected while disabled");

	property p_join_cause;
		@(posedge clk) disable iff (!arst_n)
		$rose(conn) |-> $past(join_ok) && $past(en_eff)
			&& $past(plugin_detect_n_oe) && $past(supply_ok);
	endproperty
	a_join_cause: assert property (p_join_cause)
		else $error("connection without stop or idle");

	property p_ready;
		@(posedge clk) disable iff (!arst_n)
		ready_n_oe == (state_ff == ST_CONNECTED);
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready does not follow connection");

	property p_plug;
		@(posedge clk) disable iff (!arst_n)
		$rose(plugin_detect_n_oe) |-> $past(state_ff) == ST_TERM_WAIT
			&& $past(term_cnt_ff) == TERM_LAST;
	endproperty
	a_plug: assert property (p_plug)
		else $error("plug-in detect before termination wait");

	property p_undriven_en;
		@(posedge clk) disable iff (!arst_n)
		!enable_driven && ctrl_en_ff |-> en_eff;
	endproperty
	a_undriven_en: assert property (p_undriven_en)
		else $error("undriven enable not taken as high");

	property p_por;
		@(posedge clk) disable iff (!arst_n)
		state_ff == ST_TERM_CHECK && $past(state_ff) == ST_POWERUP
			|-> $past(por_cnt_ff) == POR_LAST;
	endproperty
	a_por: assert property (p_por)
		else $error("termination check before power-up wait");

	property p_power_loss;
		@(posedge clk) disable iff (!arst_n)
		!supply_ok |=> state_ff == ST_POWERUP && !ready_n_oe
			&& !plugin_detect_n_oe;
	endproperty
	a_power_loss: assert property (p_power_loss)
		else $error("no restart after power loss");

	property p_stop_join;
		@(posedge clk) disable iff (!arst_n)
		state_ff == ST_ARMED && en_eff && supply_ok && term_valid
			&& !reseq && stop_det && card_idle |=> ready_n_oe;
	endproperty
	a_stop_join: assert property (p_stop_join)
		else $error("stop on line did not connect");

endmodule

// ### rtl/dhs_pkg.sv
// Purpose: Constants, register map and state codes of the hot-swap connect
// Assumes: 25 MHz clk, APB slave with 32-bit data, zero wait states
// Notes: Analog comparators (termination, supply) sit outside as levels

package dhs_pkg;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned POR_TIME_MS = 1;
	localparam int unsigned TERM_TIME_MS = 10;
	localparam int unsigned IDLE_TIME_US = 50;
	// Least times, rounded up to whole cycles
	localparam int unsigned POR_CYC_DEF = (POR_TIME_MS * CLK_HZ + 999) / 1000;
	localparam int unsigned TERM_CYC_DEF =
		(TERM_TIME_MS * CLK_HZ + 999) / 1000;
	localparam int unsigned IDLE_CYC_DEF =
		(IDLE_TIME_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned IDLE_W = 16;

	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_IDLE = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_RESEQ_BIT = 1;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_CONN_BIT = 5;
	localparam int unsigned STAT_PLUG_BIT = 6;
	localparam int unsigned STAT_EN_BIT = 7;
	localparam int unsigned STAT_SUP_BIT = 8;
	localparam int unsigned STAT_TERM_BIT = 9;
	localparam logic PIN_LOW = 1'h0;

	// --------------------------------------------------------------
	// States
	// --------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_POWERUP = 5'h01,
		ST_TERM_CHECK = 5'h02,
		ST_TERM_WAIT = 5'h04,
		ST_ARMED = 5'h08,
		ST_CONNECTED = 5'h10
	} dhs_state_e;

	typedef enum logic [2:0] {
		DIR_IDLE = 3'h1,
		DIR_TO_LINE = 3'h2,
		DIR_TO_CARD = 3'h4
	} dhs_dir_e;

endpackage

// ### tb/dhs_far_side.sv
// Purpose: Far side of the three channels: card pull-ups, biased pairs
// Assumes: Levels resolved combinationally from every party's pull-down
// Notes: A remote transmitter swaps the pair, plus low and minus high

module dhs_far_side (
	input wire logic [2:0] card_oe,
	input wire logic [2:0] plus_oe,
	input wire logic [2:0] minus_oe,
	input wire logic [2:0] card_pull,
	input wire logic [2:0] remote_pull,
	input wire logic [2:0] cm_high,
	output logic [2:0] card_lvl,
	output logic [2:0] plus_lvl,
	output logic [2:0] minus_lvl
);
	timeunit 1ns;
	timeprecision 1ns;

	// --------------------------------------------------------------
	// Wired levels
	// --------------------------------------------------------------
	// Card pins float high through the pull-ups when released
	assign card_lvl = ~(card_oe | card_pull);
	// Bias holds plus above minus at rest
	assign plus_lvl = ~(plus_oe | remote_pull);
	// Common-mode lift raises minus with plus, leaving no difference
	assign minus_lvl = (plus_oe | remote_pull | cm_high)
		& ~minus_oe;

endmodule

// ### tb/test_dhs_connect.sv
// Purpose: Self-checking bench of the hot-swap connect block
// Assumes: Short counts POR 8, TERM 16, IDLE 8 cycles
// Notes: Pin outputs sampled on falling edges, APB read data and error on rising edges; inputs driven on rising ones

module test_dhs_connect;
	import dhs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned POR = 8;
	localparam int unsigned TRM = 16;
	localparam int unsigned IDL = 8;

	logic clk, arst_n, supply_ok, en_lvl, en_drv, term_ok;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] card_pull, remote_pull, cm_high;
	wire logic [2:0] c_oe, p_oe, m_oe, c_lvl, p_lvl, m_lvl;
	wire logic ready_oe, plug_oe;
	wire logic [10:0] pin_o;
	logic err;
	int error_cnt, check_count, n;

	dhs_far_side u_far (.card_oe(c_oe), .plus_oe(p_oe), .minus_oe(m_oe),
		.card_pull(card_pull), .remote_pull(remote_pull),
		.cm_high(cm_high),
		.card_lvl(c_lvl), .plus_lvl(p_lvl), .minus_lvl(m_lvl));

	dhs_connect #(.POR_CYC(POR), .TERM_CYC(TRM), .IDLE_CYC(IDL)) u_dut (
		.clk(clk), .arst_n(arst_n), .supply_ok(supply_ok),
		.enable_level(en_lvl), .enable_driven(en_drv),
		.clock_term_ok(term_ok), .data_term_ok(term_ok),
		.card_clock_i(c_lvl[0]), .card_clock_o(pin_o[0]),
		.card_clock_oe(c_oe[0]),
		.card_data_i(c_lvl[1]), .card_data_o(pin_o[1]),
		.card_data_oe(c_oe[1]),
		.card_irq_i(c_lvl[2]), .card_irq_o(pin_o[2]),
		.card_irq_oe(c_oe[2]),
		.line_clock_plus_i(p_lvl[0]), .line_clock_plus_o(pin_o[3]),
		.line_clock_plus_oe(p_oe[0]),
		.line_clock_minus_i(m_lvl[0]), .line_clock_minus_o(pin_o[4]),
		.line_clock_minus_oe(m_oe[0]),
		.line_data_plus_i(p_lvl[1]), .line_data_plus_o(pin_o[5]),
		.line_data_plus_oe(p_oe[1]),
		.line_data_minus_i(m_lvl[1]), .line_data_minus_o(pin_o[6]),
		.line_data_minus_oe(m_oe[1]),
		.line_irq_plus_i(p_lvl[2]), .line_irq_plus_o(pin_o[7]),
		.line_irq_plus_oe(p_oe[2]),
		.line_irq_minus_i(m_lvl[2]), .line_irq_minus_o(pin_o[8]),
		.line_irq_minus_oe(m_oe[2]),
		.plugin_detect_n_o(pin_o[9]), .plugin_detect_n_oe(plug_oe),
		.ready_n_o(pin_o[10]), .ready_n_oe(ready_oe),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a slave that never answers
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits on falling edges for ready (sel 0) or plug-in (sel 1)
	task automatic wait_for(input int sel, input logic lvl, input int max);
		n = 0;
		while ((sel ? plug_oe : ready_oe) !== lvl && n < max) begin
			@(negedge clk);
			n++;
		end
		chk(((sel ? plug_oe : ready_oe) === lvl), 1);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_regs();
		chk({ready_oe, plug_oe, c_oe, p_oe, m_oe}, 0);
		apb(1'b0, REG_STATUS, 0);
		chk(rd[4:0], 5'h01);
		apb(1'b0, REG_CTRL, 0);
		chk(rd, 32'h1);
		chk(err, 1'b0);
		apb(1'b0, REG_IDLE, 0);
		chk(rd, IDL);
		apb(1'b0, 8'h0c, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, REG_STATUS, 32'h0);
		chk(err, 1'b1);
	endtask

	task automatic t_sequence();
		@(posedge clk);
		supply_ok <= 1'b1;
		term_ok <= 1'b1;
		wait_for(1, 1'b1, 60);
		chk(n >= POR + TRM, 1);
		repeat (20) @(negedge clk);
		chk(ready_oe, 1'b0);
		@(posedge clk);
		en_lvl <= 1'b1;
		wait_for(0, 1'b1, IDL + 4);
	endtask

	task automatic t_channels();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			card_pull[i] <= 1'b1;
			repeat (2) @(negedge clk);
			chk({c_oe[i], p_oe[i], m_oe[i]}, 3'b010);
			chk(pin_o, 11'h0);
			@(posedge clk);
			card_pull[i] <= 1'b0;
			repeat (3) @(negedge clk);
			chk({c_oe[i], p_oe[i]}, 2'b00);
			@(posedge clk);
			remote_pull[i] <= 1'b1;
			repeat (2) @(negedge clk);
			chk({c_oe[i], p_oe[i]}, 2'b10);
			@(posedge clk);
			remote_pull[i] <= 1'b0;
			repeat (3) @(negedge clk);
			chk({c_oe[i], p_oe[i]}, 2'b00);
			// Both lines lifted together: no difference reads as low
			@(posedge clk);
			cm_high[i] <= 1'b1;
			repeat (2) @(negedge clk);
			chk({c_oe[i], p_oe[i]}, 2'b10);
			@(posedge clk);
			cm_high[i] <= 1'b0;
			repeat (3) @(negedge clk);
			chk({c_oe[i], p_oe[i]}, 2'b00);
		end
	endtask

	task automatic t_enable();
		@(posedge clk);
		en_lvl <= 1'b0;
		wait_for(0, 1'b0, 4);
		chk(plug_oe, 1'b1);
		@(posedge clk);
		card_pull[1] <= 1'b1;
		repeat (3) @(negedge clk);
		chk(p_oe, 3'b000);
		@(posedge clk);
		card_pull[1] <= 1'b0;
		en_drv <= 1'b0;
		wait_for(0, 1'b1, IDL + 6);
	endtask

	task automatic t_stop();
		@(posedge clk);
		en_drv <= 1'b1;
		en_lvl <= 1'b1;
		remote_pull[1] <= 1'b1;
		apb(1'b1, REG_CTRL, 32'h3);
		wait_for(0, 1'b0, 4);
		wait_for(1, 1'b1, 60);
		repeat (IDL + 4) @(negedge clk);
		chk(ready_oe, 1'b0);
		@(posedge clk);
		remote_pull[1] <= 1'b0;
		wait_for(0, 1'b1, 3);
	endtask

	task automatic t_term();
		@(posedge clk);
		term_ok <= 1'b0;
		wait_for(0, 1'b0, 3);
		chk({plug_oe, c_oe, p_oe}, 0);
		// Unused interrupt channel: card pin held low
		@(posedge clk);
		card_pull[2] <= 1'b1;
		repeat (3) @(negedge clk);
		chk(p_oe, 3'b000);
	endtask

	// --------------------------------------------------------------
	// Run control
	// --------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(40 * 5000);
		error_cnt++;
		stop_test();
	end

	initial begin
		error_cnt = 0;
		check_count = 0;
		arst_n = 1'b0;
		supply_ok = 1'b0;
		term_ok = 1'b0;
		en_lvl = 1'b0;
		en_drv = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		card_pull = 3'h0;
		remote_pull = 3'h0;
		cm_high = 3'h0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_sequence();
		t_channels();
		t_enable();
		t_stop();
		t_term();
		stop_test();
	end

endmodule
